// >>> acif_pkg.sv
// constants for the audio clock and interface configuration registers
package acif_pkg;
   // register addresses seen on the serial control port
   localparam logic [7:0] ACIF_ADDR_CLK_SRC  = 8'h08;
   localparam logic [7:0] ACIF_ADDR_IFACE    = 8'h09;
   localparam logic [7:0] ACIF_ADDR_PWR_PIN  = 8'h0A;
   // reset values
   localparam logic [7:0] ACIF_RST_CLK_SRC   = 8'h00;
   localparam logic [7:0] ACIF_RST_IFACE     = 8'h00;
   localparam logic [7:0] ACIF_RST_PWR_PIN   = 8'h00;
   // writable bits; reserved bits always store zero
   localparam logic [7:0] ACIF_MASK_CLK_SRC  = 8'h7F;
   localparam logic [7:0] ACIF_MASK_IFACE    = 8'h3F;
   localparam logic [7:0] ACIF_MASK_PWR_PIN  = 8'hBF;
   // clock_source_select fields
   localparam int CS_PLL_REF   = 0;
   localparam int CS_HALVE     = 1;
   localparam int CS_AUDIO_SEL = 2;
   localparam int CS_VOICE_SEL = 3;
   localparam int CS_PLL_PD    = 4;
   localparam int CS_QDIV_LO   = 5;
   localparam int CS_QDIV_HI   = 6;
   // interface_format fields
   localparam int IF_COMPANDED = 0;
   localparam int IF_ALAW      = 1;
   localparam int IF_VMASTER   = 2;
   localparam int IF_LONG      = 3;
   localparam int IF_SMASTER   = 4;
   localparam int IF_WORD32    = 5;
   // power_and_pin_config fields
   localparam int PP_ZX_BYPASS = 0;
   localparam int PP_DLY_LO    = 1;
   localparam int PP_DLY_HI    = 2;
   localparam int PP_PIN_LO    = 3;
   localparam int PP_PIN_HI    = 5;
   localparam int PP_DITHER    = 7;
   // voice clock divide values indexed by the two-bit field
   localparam logic [3:0] ACIF_QDIV_0 = 4'hC;
   localparam logic [3:0] ACIF_QDIV_1 = 4'h8;
   localparam logic [3:0] ACIF_QDIV_2 = 4'h6;
   localparam logic [3:0] ACIF_QDIV_3 = 4'h4;
   // serial control word
   localparam logic [4:0] ACIF_SPI_BITS = 5'h10;
   // voice and stereo word formats
   localparam int ACIF_VOICE_LIN_BITS  = 16;
   localparam int ACIF_VOICE_COMP_BITS = 8;
   localparam int ACIF_STEREO_USED     = 18;
   // turn-on delays, quoted at the reference audio clock
   localparam int ACIF_REF_CLK_KHZ = 12288;
   localparam int ACIF_DLY_SHORT_MS = 25;
   localparam int ACIF_DLY_MED_MS   = 100;
   localparam int ACIF_DLY_LONG_MS  = 200;
   localparam int ACIF_DLY_TEST_MS  = 1;
   localparam int ACIF_DLY_SHORT_TICKS = ACIF_DLY_SHORT_MS * ACIF_REF_CLK_KHZ;
   localparam int ACIF_DLY_MED_TICKS   = ACIF_DLY_MED_MS * ACIF_REF_CLK_KHZ;
   localparam int ACIF_DLY_LONG_TICKS  = ACIF_DLY_LONG_MS * ACIF_REF_CLK_KHZ;
   localparam int ACIF_DLY_TEST_TICKS  = ACIF_DLY_TEST_MS * ACIF_REF_CLK_KHZ;
   // multi-use pin functions
   typedef enum logic [2:0] {
      ACIF_PIN_HP      = 3'b000,
      ACIF_PIN_VCLK    = 3'b001,
      ACIF_PIN_DATA    = 3'b010,
      ACIF_PIN_EXT_SPK = 3'b011,
      ACIF_PIN_VADC    = 3'b100,
      ACIF_PIN_VDAC    = 3'b101,
      ACIF_PIN_LDAC    = 3'b110,
      ACIF_PIN_RDAC    = 3'b111
   } acif_pin_t;
endpackage

// >>> acif_div.sv
// divides a stream of source-clock ticks into an even-ratio clock
`timescale 1ns/1ps
module acif_div #(
   parameter int W = 4
) (
   input  wire logic         clk,       // system clock
   input  wire logic         arst_n,    // async reset, active low
   input  wire logic         src_tick,  // one pulse per source rising edge
   input  wire logic [W-1:0] divisor,   // even divide ratio
   output logic              clk_out    // divided clock, registered
);
   logic [W-1:0] cnt_reg;
   logic [W-1:0] half;

   assign half = divisor >> 1;

   // toggle every half ratio of source ticks; a changed ratio applies at once to the count in progress
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= '0;
         clk_out <= 1'b0;
      end else if (src_tick) begin
         if (cnt_reg >= half - W'(1)) begin
            cnt_reg <= '0;
            clk_out <= ~clk_out;
         end else begin
            cnt_reg <= cnt_reg + W'(1);
         end
      end
   end
endmodule

// >>> acif_regs.sv
// audio clock, serial port format and power/pin configuration registers
`timescale 1ns/1ps
module acif_regs
   import acif_pkg::*;
#(
   parameter logic [23:0] DLY_SHORT_TICKS = 24'(acif_pkg::ACIF_DLY_SHORT_TICKS),
   parameter logic [23:0] DLY_MED_TICKS   = 24'(acif_pkg::ACIF_DLY_MED_TICKS),
   parameter logic [23:0] DLY_LONG_TICKS  = 24'(acif_pkg::ACIF_DLY_LONG_TICKS),
   parameter logic [23:0] DLY_TEST_TICKS  = 24'(acif_pkg::ACIF_DLY_TEST_TICKS)
) (
   input  wire logic       clk,                      // system clock, 50 MHz
   input  wire logic       arst_n,                   // async reset, active low
   input  wire logic       spi_sck,                  // control port clock
   input  wire logic       spi_sdi,                  // control port data, msb first
   input  wire logic       spi_enb_n,                // control port enable, active low
   input  wire logic       mclk_in,                  // master clock pin, sampled
   input  wire logic       bclk_in,                  // stereo port bit clock, sampled
   input  wire logic       pll_clk_in,               // pll output, sampled
   input  wire logic       voice_codec_enable,       // voice codec powered
   input  wire logic       powerup_req,              // start of turn-on sequence
   input  wire logic       headphone_present,        // headphone sense
   input  wire logic       gpio_data_value,          // general data for the pin
   input  wire logic       external_speaker_enable,  // external amp enable
   input  wire logic       voice_adc_serial_out,     // voice adc serial data
   input  wire logic       voice_dac_serial_out,     // voice dac serial data
   input  wire logic       left_dac_serial_out,      // left dac serial data
   input  wire logic       right_dac_serial_out,     // right dac serial data
   output logic            pll_ref_clk,              // selected pll reference
   output logic            pll_powerdown,            // pll off
   output logic            audio_clk,                // audio dac clock
   output logic            voice_clk,                // voice codec clock
   output logic            voice_companded,          // voice data companded
   output logic            companding_law_select,    // 1 a-law, 0 mu-law
   output logic            voice_port_master,        // voice port drives clock/sync
   output logic            voice_long_frame,         // long frame sync
   output logic [4:0]      voice_word_bits,          // active voice bits per sync
   output logic            stereo_port_master,       // stereo port master
   output logic            stereo_word_32,           // 32-bit stereo words
   output logic [4:0]      stereo_used_bits,         // stereo bits passed on
   output logic            zero_cross_bypass,        // changes skip zero crossing
   output logic            turnon_done,              // turn-on delay elapsed
   output logic            class_d_dither,           // class-d modulator dither
   output logic            gpio_out                  // multi-use pin level
);
   import acif_pkg::*;

   logic [7:0]  clk_src_reg;
   logic [7:0]  iface_reg;
   logic [7:0]  pwr_pin_reg;
   logic        sck_prev_reg;
   logic        enb_prev_reg;
   logic [15:0] shift_reg;
   logic [4:0]  bit_cnt_reg;
   logic        wr_stb;
   logic [7:0]  wr_addr;
   logic [7:0]  wr_data;
   logic        mclk_prev_reg;
   logic        pll_prev_reg;
   logic        mclk_half_reg;
   logic        mclk_rise;
   logic        mclk_eff;
   logic        mclk_eff_tick;
   logic        pll_tick;
   logic        audio_tick;
   logic        voice_tick;
   logic [3:0]  qdiv;
   logic        voice_div_clk;
   logic [23:0] dly_cnt_reg;
   logic        pwr_req_prev_reg;
   logic        dly_run_reg;
   acif_pin_t   pin_sel;
   logic        pin_level;

   // serial control word: 16 bits on rising sck while enable is low, extra bits dropped
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sck_prev_reg <= 1'b0;
         enb_prev_reg <= 1'b1;
         shift_reg    <= 16'h0000;
         bit_cnt_reg  <= 5'h00;
      end else begin
         sck_prev_reg <= spi_sck;
         enb_prev_reg <= spi_enb_n;
         if (spi_enb_n) begin
            bit_cnt_reg <= 5'h00;
         end else if (spi_sck && !sck_prev_reg && bit_cnt_reg < ACIF_SPI_BITS) begin
            shift_reg   <= {shift_reg[14:0], spi_sdi};
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
         end
      end
   end

   // a word is latched only when enable rises after all 16 bits; a short word is aborted
   assign wr_stb  = spi_enb_n && !enb_prev_reg && (bit_cnt_reg == ACIF_SPI_BITS);
   assign wr_addr = shift_reg[15:8];
   assign wr_data = shift_reg[7:0];

   // register writes; reserved bits are masked so they always read back as zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         clk_src_reg <= ACIF_RST_CLK_SRC;
         iface_reg   <= ACIF_RST_IFACE;
         pwr_pin_reg <= ACIF_RST_PWR_PIN;
      end else if (wr_stb) begin
         if (wr_addr == ACIF_ADDR_CLK_SRC) begin
            clk_src_reg <= wr_data & ACIF_MASK_CLK_SRC;
         end
         if (wr_addr == ACIF_ADDR_IFACE) begin
            iface_reg <= wr_data & ACIF_MASK_IFACE;
         end
         if (wr_addr == ACIF_ADDR_PWR_PIN) begin
            pwr_pin_reg <= wr_data & ACIF_MASK_PWR_PIN;
         end
      end
   end

   // clock pin edge tracking; pins are slow next to clk so one sample is enough
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mclk_prev_reg <= 1'b0;
         pll_prev_reg  <= 1'b0;
         mclk_half_reg <= 1'b0;
      end else begin
         mclk_prev_reg <= mclk_in;
         pll_prev_reg  <= pll_clk_in;
         if (mclk_rise) begin
            mclk_half_reg <= ~mclk_half_reg;
         end
      end
   end

   assign mclk_rise     = mclk_in && !mclk_prev_reg;
   // halving path: the master clock is divided before anything else uses it
   assign mclk_eff      = clk_src_reg[CS_HALVE] ? mclk_half_reg : mclk_in;
   assign mclk_eff_tick = mclk_rise && (!clk_src_reg[CS_HALVE] || !mclk_half_reg);
   // a powered-down pll delivers no edges
   assign pll_tick      = pll_clk_in && !pll_prev_reg && !clk_src_reg[CS_PLL_PD];
   assign audio_tick    = clk_src_reg[CS_AUDIO_SEL] ? mclk_eff_tick : pll_tick;
   assign voice_tick    = clk_src_reg[CS_VOICE_SEL] ? mclk_eff_tick : pll_tick;

   // voice divide ratio from the two-bit field
   always_comb begin
      unique case (clk_src_reg[CS_QDIV_HI:CS_QDIV_LO])
         2'b00: qdiv = ACIF_QDIV_0;
         2'b01: qdiv = ACIF_QDIV_1;
         2'b10: qdiv = ACIF_QDIV_2;
         2'b11: qdiv = ACIF_QDIV_3;
      endcase
   end

   // voice codec clock: 12.288 MHz over 12 gives 128 times 8 kHz
   acif_div #(
      .W        (4)
   ) u_voice_div (
      .clk      (clk),
      .arst_n   (arst_n),
      .src_tick (voice_tick),
      .divisor  (qdiv),
      .clk_out  (voice_div_clk)
   );

   // clock outputs; the dac takes the pll or master clock per the audio select bit, voice a divided clock
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pll_ref_clk   <= 1'b0;
         pll_powerdown <= 1'b0;
         audio_clk     <= 1'b0;
         voice_clk     <= 1'b0;
      end else begin
         pll_ref_clk   <= clk_src_reg[CS_PLL_REF] ? bclk_in : mclk_eff;
         pll_powerdown <= clk_src_reg[CS_PLL_PD];
         audio_clk     <= clk_src_reg[CS_AUDIO_SEL] ? mclk_eff
                                                    : (pll_clk_in && !clk_src_reg[CS_PLL_PD]);
         voice_clk     <= voice_div_clk;
      end
   end

   // serial port formats
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         voice_companded       <= 1'b0;
         companding_law_select <= 1'b0;
         voice_port_master     <= 1'b0;
         voice_long_frame      <= 1'b0;
         voice_word_bits       <= 5'(ACIF_VOICE_LIN_BITS);
         stereo_port_master    <= 1'b0;
         stereo_word_32        <= 1'b0;
         stereo_used_bits      <= 5'(ACIF_VOICE_LIN_BITS);
      end else begin
         voice_companded       <= iface_reg[IF_COMPANDED];
         companding_law_select <= iface_reg[IF_ALAW];
         voice_port_master     <= iface_reg[IF_VMASTER];
         voice_long_frame      <= iface_reg[IF_LONG];
         voice_word_bits       <= iface_reg[IF_COMPANDED] ? 5'(ACIF_VOICE_COMP_BITS)
                                                          : 5'(ACIF_VOICE_LIN_BITS);
         stereo_port_master    <= iface_reg[IF_SMASTER];
         stereo_word_32        <= iface_reg[IF_WORD32];
         stereo_used_bits      <= iface_reg[IF_WORD32] ? 5'(ACIF_STEREO_USED)
                                                       : 5'(ACIF_VOICE_LIN_BITS);
      end
   end

   // turn-on delay counts audio clock ticks, so it scales inversely with that clock
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pwr_req_prev_reg <= 1'b0;
         dly_run_reg      <= 1'b0;
         dly_cnt_reg      <= 24'h000000;
         turnon_done      <= 1'b0;
      end else begin
         pwr_req_prev_reg <= powerup_req;
         if (!powerup_req) begin
            dly_run_reg <= 1'b0;
            turnon_done <= 1'b0;
         end else if (!pwr_req_prev_reg) begin
            dly_run_reg <= 1'b1;
            turnon_done <= 1'b0;
            unique case (pwr_pin_reg[PP_DLY_HI:PP_DLY_LO])
               2'b00: dly_cnt_reg <= DLY_SHORT_TICKS;
               2'b01: dly_cnt_reg <= DLY_MED_TICKS;
               2'b10: dly_cnt_reg <= DLY_LONG_TICKS;
               2'b11: dly_cnt_reg <= DLY_TEST_TICKS;
            endcase
         end else if (dly_run_reg && audio_tick) begin
            if (dly_cnt_reg <= 24'h000001) begin
               dly_run_reg <= 1'b0;
               turnon_done <= 1'b1;
            end else begin
               dly_cnt_reg <= dly_cnt_reg - 24'h000001;
            end
         end
      end
   end

   // multi-use pin source; voice clock only appears while the codec is enabled
   assign pin_sel = acif_pin_t'(pwr_pin_reg[PP_PIN_HI:PP_PIN_LO]);
   always_comb begin
      unique case (pin_sel)
         ACIF_PIN_HP:      pin_level = headphone_present;
         ACIF_PIN_VCLK:    pin_level = voice_div_clk && voice_codec_enable;
         ACIF_PIN_DATA:    pin_level = gpio_data_value;
         ACIF_PIN_EXT_SPK: pin_level = external_speaker_enable;
         ACIF_PIN_VADC:    pin_level = voice_adc_serial_out;
         ACIF_PIN_VDAC:    pin_level = voice_dac_serial_out;
         ACIF_PIN_LDAC:    pin_level = left_dac_serial_out;
         ACIF_PIN_RDAC:    pin_level = right_dac_serial_out;
      endcase
   end

   // power and pin outputs
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         zero_cross_bypass <= 1'b0;
         class_d_dither    <= 1'b0;
         gpio_out          <= 1'b0;
      end else begin
         zero_cross_bypass <= pwr_pin_reg[PP_ZX_BYPASS];
         class_d_dither    <= pwr_pin_reg[PP_DITHER];
         gpio_out          <= pin_level;
      end
   end

   // checks on the registers and driven outputs
   AST_CLK_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
      (wr_stb && wr_addr == ACIF_ADDR_CLK_SRC) |=> clk_src_reg == (($past(wr_data)) & ACIF_MASK_CLK_SRC))
      else $error("clock source register did not take the write");
   AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!arst_n)
      !clk_src_reg[7] && iface_reg[7:6] == 2'b00 && !pwr_pin_reg[6])
      else $error("reserved bit stored a one");
   AST_PLL_PD: assert property (@(posedge clk) disable iff (!arst_n)
      clk_src_reg[CS_PLL_PD] |-> !pll_tick ##1 pll_powerdown)
      else $error("pll not powered down");
   AST_VOICE_DIV: assert property (@(posedge clk) disable iff (!arst_n)
      !voice_tick |=> $stable(voice_div_clk))
      else $error("voice clock moved without a source tick");
   AST_VCLK_GATE: assert property (@(posedge clk) disable iff (!arst_n)
      (pin_sel == ACIF_PIN_VCLK && !voice_codec_enable) |=> !gpio_out)
      else $error("voice clock on pin while codec disabled");
   AST_WORD_LEN: assert property (@(posedge clk) disable iff (!arst_n)
      iface_reg[IF_WORD32] ##1 iface_reg[IF_WORD32] |-> stereo_used_bits == 5'(ACIF_STEREO_USED))
      else $error("stereo used bits wrong in 32-bit mode");
   AST_REF_SEL: assert property (@(posedge clk) disable iff (!arst_n)
      clk_src_reg[CS_PLL_REF] |=> pll_ref_clk == $past(bclk_in))
      else $error("pll reference not taken from bit clock");
   AST_HALVE: assert property (@(posedge clk) disable iff (!arst_n)
      (clk_src_reg[CS_HALVE] && !clk_src_reg[CS_PLL_REF]) |=> pll_ref_clk == $past(mclk_half_reg))
      else $error("pll reference not taken from halved master clock");
   AST_SHORT_ABORT: assert property (@(posedge clk) disable iff (!arst_n)
      (spi_enb_n && !enb_prev_reg && bit_cnt_reg != ACIF_SPI_BITS) |=> $stable(iface_reg))
      else $error("short control word changed a register");
endmodule

// >>> acif_regs_tb_top.sv
// self-checking bench for the audio clock and interface configuration registers
`timescale 1ns/1ps
module acif_regs_tb_top;
   import acif_pkg::*;
   logic       clk, arst_n, spi_sck, spi_sdi, spi_enb_n, mclk_in, bclk_in, pll_clk_in;
   logic       voice_codec_enable, powerup_req, mclk_run, pll_run;
   logic [7:0] src;
   logic [1:0] ph;
   logic       pll_ref_clk, pll_powerdown, audio_clk, voice_clk, voice_companded, companding_law_select;
   logic       voice_port_master, voice_long_frame, stereo_port_master, stereo_word_32;
   logic       zero_cross_bypass, turnon_done, class_d_dither, gpio_out;
   logic [4:0] voice_word_bits, stereo_used_bits;
   int         failures, checks_done, cycles, p, n;
   acif_regs #(.DLY_SHORT_TICKS(24'h000008), .DLY_MED_TICKS(24'h000010), .DLY_LONG_TICKS(24'h000018),
      .DLY_TEST_TICKS(24'h000004)) i_dut (.clk(clk), .arst_n(arst_n), .spi_sck(spi_sck), .spi_sdi(spi_sdi),
      .spi_enb_n(spi_enb_n), .mclk_in(mclk_in), .bclk_in(bclk_in), .pll_clk_in(pll_clk_in),
      .voice_codec_enable(voice_codec_enable), .powerup_req(powerup_req), .headphone_present(src[0]),
      .gpio_data_value(src[2]), .external_speaker_enable(src[3]), .voice_adc_serial_out(src[4]),
      .voice_dac_serial_out(src[5]), .left_dac_serial_out(src[6]), .right_dac_serial_out(src[7]),
      .pll_ref_clk(pll_ref_clk), .pll_powerdown(pll_powerdown), .audio_clk(audio_clk), .voice_clk(voice_clk),
      .voice_companded(voice_companded), .companding_law_select(companding_law_select),
      .voice_port_master(voice_port_master), .voice_long_frame(voice_long_frame),
      .voice_word_bits(voice_word_bits), .stereo_port_master(stereo_port_master),
      .stereo_word_32(stereo_word_32), .stereo_used_bits(stereo_used_bits),
      .zero_cross_bypass(zero_cross_bypass), .turnon_done(turnon_done), .class_d_dither(class_d_dither),
      .gpio_out(gpio_out));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // clock pins toggle every two system cycles, well inside what sampling can follow
   always @(posedge clk) begin
      ph <= ph + 2'h1;
      if (mclk_run) mclk_in <= ph[1];
      if (pll_run) pll_clk_in <= ph[1];
   end
   // hang guard: generous against the few thousand cycles the tests need
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 50000) begin
         failures++;
         test_done();
      end
   end
   task automatic chk_bits(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic chk_count(input string name, input int exp, input int got);
      checks_done++;
      if (got != exp) begin
         failures++;
         $display("mismatch %s expected %0d seen %0d", name, exp, got);
      end
   endtask
   // one control word, msb first; nbits below 16 leaves the transfer short
   task automatic spi_xfer(input logic [7:0] addr, input logic [7:0] data, input int nbits);
      logic [15:0] w;
      w = {addr, data};
      @(posedge clk) spi_enb_n <= 1'b0;
      for (int i = 15; i > 15 - nbits; i--) begin
         @(posedge clk) spi_sdi <= w[i];
         @(posedge clk) spi_sck <= 1'b1;
         repeat (2) @(posedge clk);
         spi_sck <= 1'b0;
         repeat (2) @(posedge clk);
      end
      spi_enb_n <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
   endtask
   // cycles between two rises of the voice clock, taken on the second period
   task automatic vperiod(output int per);
      logic prev;
      int rises;
      per = 0;
      rises = 0;
      prev = voice_clk;
      for (int i = 0; i < 3000 && rises < 3; i++) begin
         @(negedge clk);
         if (rises == 2) per++;
         if (voice_clk === 1'b1 && prev === 1'b0) rises++;
         prev = voice_clk;
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      {spi_sck, spi_sdi, mclk_in, bclk_in, pll_clk_in, voice_codec_enable, powerup_req} = '0;
      {mclk_run, pll_run, ph, src, cycles, failures, checks_done} = '0;
      spi_enb_n = 1'b1;
      arst_n = 1'b0;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      #1;
      chk_bits("reset_words", 8'h10, {3'h0, voice_word_bits});
      chk_bits("reset_stereo", 8'h10, {3'h0, stereo_used_bits});
      chk_bits("reset_flags", 8'h00, {pll_powerdown, voice_companded, stereo_word_32, class_d_dither, gpio_out});
      // interface format, every writable bit set then a short transfer that must not land
      spi_xfer(ACIF_ADDR_IFACE, 8'h3F, 16);
      chk_bits("iface", 8'h3F, {2'h0, stereo_word_32, stereo_port_master, voice_long_frame, voice_port_master,
         companding_law_select, voice_companded});
      chk_bits("word_bits", 8'h08, {3'h0, voice_word_bits});
      chk_bits("stereo_used32", 8'h12, {3'h0, stereo_used_bits});
      spi_xfer(ACIF_ADDR_IFACE, 8'h00, 8);
      chk_bits("iface_abort", 8'h01, {7'h0, voice_companded});
      spi_xfer(8'h0B, 8'h00, 16);
      chk_bits("iface_unmapped", 8'h01, {7'h0, stereo_word_32});
      spi_xfer(ACIF_ADDR_IFACE, 8'h00, 16);
      chk_bits("word_bits_lin", 8'h10, {3'h0, voice_word_bits});
      chk_bits("stereo_used16", 8'h10, {3'h0, stereo_used_bits});
      // power and pin: bypass, dither, then every pin function
      spi_xfer(ACIF_ADDR_PWR_PIN, 8'h81, 16);
      chk_bits("pwr_bits", 8'h03, {6'h0, class_d_dither, zero_cross_bypass});
      for (int c = 0; c < 8; c++) begin
         spi_xfer(ACIF_ADDR_PWR_PIN, 8'(c << 3), 16);
         src <= 8'h01 << c;
         repeat (3) @(posedge clk);
         #1;
         chk_bits("pin_sel", (c == 1) ? 8'h00 : 8'h01, {7'h0, gpio_out});
         src <= ~(8'h01 << c);
         repeat (3) @(posedge clk);
         #1;
         chk_bits("pin_inv", 8'h00, {7'h0, gpio_out});
      end
      // reference and audio source selection with static pin levels
      bclk_in <= 1'b1;
      spi_xfer(ACIF_ADDR_CLK_SRC, 8'h11, 16);
      chk_bits("pll_ref_bclk", 8'h03, {6'h0, pll_ref_clk, pll_powerdown});
      mclk_in <= 1'b1;
      spi_xfer(ACIF_ADDR_CLK_SRC, 8'h04, 16);
      chk_bits("mclk_paths", 8'h06, {5'h0, pll_ref_clk, audio_clk, pll_powerdown});
      mclk_in <= 1'b0;
      pll_clk_in <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk_bits("audio_mclk", 8'h00, {6'h0, pll_ref_clk, audio_clk});
      // voice divider from the pll ticks, then from the halved master clock
      pll_run <= 1'b1;
      mclk_run <= 1'b1;
      for (int q = 0; q < 4; q++) begin
         spi_xfer(ACIF_ADDR_CLK_SRC, 8'(q << 5), 16);
         vperiod(p);
         n = (q == 0) ? 12 : (q == 1) ? 8 : (q == 2) ? 6 : 4;
         chk_count("voice_pll_period", n * 4, p);
      end
      spi_xfer(ACIF_ADDR_CLK_SRC, 8'h6A, 16);
      vperiod(p);
      chk_count("voice_halved_period", 32, p);
      // voice clock reaches the pin once the codec is enabled; one edge lets the enable settle
      spi_xfer(ACIF_ADDR_PWR_PIN, 8'h08, 16);
      voice_codec_enable <= 1'b1;
      @(posedge clk);
      n = 0;
      p = 0;
      repeat (96) begin
         @(negedge clk);
         n += (gpio_out === 1'b1);
         p += (gpio_out !== voice_clk);
      end
      chk_count("vclk_pin_diff", 0, p);
      chk_bits("vclk_pin_runs", 8'h01, {7'h0, (n > 0) && (n < 96)});
      // turn-on delay counted in audio clock ticks from the pll
      spi_xfer(ACIF_ADDR_CLK_SRC, 8'h00, 16);
      for (int d = 0; d < 4; d++) begin
         spi_xfer(ACIF_ADDR_PWR_PIN, 8'(d << 1), 16);
         powerup_req <= 1'b1;
         n = 0;
         for (int i = 0; i < 400 && turnon_done !== 1'b1; i++) begin
            @(negedge clk);
            n++;
         end
         p = (d == 0) ? 8 : (d == 1) ? 16 : (d == 2) ? 24 : 4;
         chk_bits("turnon_window", 8'h01, {7'h0, (n >= p * 4 - 4) && (n <= p * 4 + 8)});
         @(posedge clk) powerup_req <= 1'b0;
         repeat (3) @(posedge clk);
      end
      // a second reset in mid-run clears the stored settings
      spi_xfer(ACIF_ADDR_IFACE, 8'h3F, 16);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      #1;
      chk_bits("rereset", 8'h00, {stereo_word_32, voice_companded, turnon_done, zero_cross_bypass});
      test_done();
   end
endmodule
